// ===== logic/pds_consts.vh
// constants for the processor decode and status block
// assumes inclusion by pds_core.v and by the checker and the bench (the sequencer model does not include it)
`ifndef PDS_CONSTS_VH
`define PDS_CONSTS_VH
// register byte offsets on the axi4-lite slave
`define OFF_CTRL        8'h00
`define OFF_IRQ_STATUS  8'h04
`define OFF_IRQ_ENABLE  8'h08
`define OFF_IRQ_CLEAR   8'h0C
`define OFF_STATE       8'h10
`define OFF_POINTER     8'h14
// reset values
`define RST_STACK_LIMIT 8'h00
`define RST_IRQ_ENABLE  5'h00
`define RST_INSTR       16'h0000
`define RST_STATUS      8'h00
// bus address decode targets (18-bit; scratch is matched on bits 17:4 only)
`define ADDR_STATUS     18'h3FFFE
`define ADDR_STACK_LIM  18'h3FFFC
`define ADDR_SCRATCH    14'h3FFC
`define ADDR_SWITCH     18'h3FF78
// forced micro-address vectors
`define VEC_INIT        9'h001
`define VEC_POWER       9'h002
`define VEC_BUS_ERR     9'h003
`define VEC_OVERFLOW    9'h004
// interrupt status bit positions
`define IRQ_BUS_ERR     0
`define IRQ_RED_ZONE    1
`define IRQ_POWER       2
`define IRQ_INIT        3
`define IRQ_OVERFLOW    4
// axi response codes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ===== logic/pds_core.v
// processor decode and status: instruction register, decode, bus address
// decode, stack sensing, pointer drivers, forced micro-address, status word
// assumes a microprogram sequencer on clk_sys and an axi4-lite master
//
// Function
// RQ1 - display shows inverted internal data mux
// RQ2 - decode bus address into four selects
// RQ3 - stack overflow raises overflow stop and flag
// RQ4 - zero data flag when temp register zero
// RQ5 - two buffered copies of micro pointer
// RQ6 - instruction register loads during fetch, holds
// RQ7 - raw instruction bits go to branch, scratch
// RQ8 - decode opcode, format, register into controls
// RQ9 - four events force the micro pointer
// RQ10 - drive set and clear onto pointer bits
// RQ11 - pulse microword load after forcing
// RQ12 - status byte loads from mux or codes
// RQ13 - status gated onto bus or read bus
// RQ14 - status bits go to branch logic
// RQ15 - source and destination register fields
// RQ16 - past pointer captures pointer every clock
// RQ17 - initialise clears status and instruction first
// RQ18 - one forcing event per cycle, fixed priority
`include "pds_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pds_core #(
  parameter ADDR_W = 8
) (
  input  wire              clk_sys,
  input  wire              rst_n,
  input  wire              clk_en,
  input  wire [15:0]       internal_data_mux,
  input  wire [15:0]       temp_data_reg,
  input  wire [17:0]       bus_addr,
  input  wire              stack_ref,
  input  wire [8:0]        micro_pointer,
  input  wire              ir_load,
  input  wire              status_load_mux,
  input  wire              status_load_cc,
  input  wire [7:0]        cond_code_in,
  input  wire              status_to_bus,
  input  wire              status_to_read,
  input  wire              sys_init,
  input  wire              bus_error,
  input  wire              power_restart,
  input  wire              console_init,
  output reg  [15:0]       data_display,
  output reg               sel_status,
  output reg               sel_stack_limit,
  output reg               sel_scratch,
  output reg               sel_switch,
  output reg               overflow_stop,
  output reg               overflow_flag,
  output reg               zero_data,
  output reg  [8:0]        buffered_micro_pointer,
  output reg  [8:0]        expansion_micro_pointer,
  output reg  [8:0]        past_micro_pointer,
  output reg  [15:0]       instr_reg,
  output reg  [2:0]        src_reg_num,
  output reg  [2:0]        dst_reg_num,
  output reg  [5:0]        ir_branch_bits,
  output reg  [3:0]        alu_func,
  output reg               fmt_double,
  output reg               fmt_single,
  output reg               fmt_branch,
  output reg               src_is_pc,
  output reg               dst_is_pc,
  output reg  [8:0]        forced_set,
  output reg  [8:0]        forced_clr,
  output reg               forced_micro_address,
  output reg               uword_load,
  output reg  [7:0]        proc_status_word,
  output reg  [7:0]        sys_bus_data_lo,
  output reg  [7:0]        reg_read_lo,
  output reg               irq,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_FORCE = 2'd1;
  localparam ST_LOAD  = 2'd2;
  ////////////////////////////////////////////////////////////////////////////
  // register index match, used for write and read decode
  function is_off(input [ADDR_W-1:0] a, input [7:0] off);
    is_off = (a[7:2] == off[7:2]);
  endfunction
  // true when a 3-bit register field names the program counter
  function reg_is_pc(input [2:0] r);
    reg_is_pc = (r == 3'h7);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  reg [1:0] rst_sync_r;
  wire      rst_s_n = rst_sync_r[1];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      rst_sync_r <= 2'b00;
    else if (clk_en)
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  reg [1:0] pin_meta_r;
  reg [1:0] pin_sync_r;
  reg [1:0] pin_prev_r;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rst_s_n) begin
        if (!rst_s_n) begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
          pin_prev_r[gi] <= 1'b0;
        end else if (clk_en) begin
          pin_meta_r[gi] <= (gi == 0) ? power_restart : console_init;
          pin_sync_r[gi] <= pin_meta_r[gi];
          pin_prev_r[gi] <= pin_sync_r[gi];
        end
      end
    end
  endgenerate
  wire power_evt = pin_sync_r[0] & ~pin_prev_r[0];
  wire init_evt  = pin_sync_r[1] & ~pin_prev_r[1];
  ////////////////////////////////////////////////////////////////////////////
  // software registers
  reg [7:0] stack_limit_reg;
  reg [4:0] irq_enable_r;
  reg [4:0] irq_status_r;
  // stack sensing and address decode
  wire ovf_zone = stack_ref & (bus_addr[15:8] <= stack_limit_reg);  // [RQ3]
  wire red_zone = stack_ref & (bus_addr[15:8] <  stack_limit_reg);
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      data_display    <= 16'h0000;
      {sel_status, sel_stack_limit, sel_scratch, sel_switch} <= 4'h0;
      {overflow_stop, overflow_flag, zero_data} <= 3'h0;
    end else if (clk_en) begin
      data_display    <= ~internal_data_mux;                      // [RQ1]
      sel_status      <= (bus_addr == `ADDR_STATUS);              // [RQ2]
      sel_stack_limit <= (bus_addr == `ADDR_STACK_LIM);           // [RQ2]
      sel_scratch     <= (bus_addr[17:4] == `ADDR_SCRATCH);       // [RQ2]
      sel_switch      <= (bus_addr == `ADDR_SWITCH);              // [RQ2]
      overflow_stop   <= ovf_zone;                                // [RQ3]
      overflow_flag   <= ovf_zone;                                // [RQ3]
      zero_data       <= (temp_data_reg == 16'h0000);             // [RQ4]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pointer drivers and history
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      {buffered_micro_pointer, expansion_micro_pointer, past_micro_pointer} <= 27'h0000000;
    end else if (clk_en) begin
      buffered_micro_pointer  <= micro_pointer;                   // [RQ5]
      expansion_micro_pointer <= micro_pointer;                   // [RQ5]
      past_micro_pointer      <= micro_pointer;                   // [RQ16]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // instruction register, status word and decode
  wire init_any = sys_init | init_evt;
  wire [15:0] ir_src = instr_reg;
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      {instr_reg, proc_status_word} <= {`RST_INSTR, `RST_STATUS};
    end else if (clk_en) begin
      if (init_any) begin
        {instr_reg, proc_status_word} <= {`RST_INSTR, `RST_STATUS}; // [RQ17]
      end else begin
        if (ir_load)
          instr_reg <= internal_data_mux;                         // [RQ6]
        if (status_load_mux)
          proc_status_word <= internal_data_mux[7:0];             // [RQ12]
        else if (status_load_cc)
          proc_status_word <= cond_code_in;                       // [RQ12]
      end
    end
  end
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      {src_reg_num, dst_reg_num, ir_branch_bits, alu_func} <= 16'h0000;
      {fmt_double, fmt_single, fmt_branch, src_is_pc, dst_is_pc} <= 5'h00;
      {sys_bus_data_lo, reg_read_lo} <= 16'h0000;
    end else if (clk_en) begin
      src_reg_num     <= ir_src[8:6];                             // [RQ15] [RQ7]
      dst_reg_num     <= ir_src[2:0];                             // [RQ15] [RQ7]
      ir_branch_bits  <= {ir_src[15], ir_src[11:9], ir_src[5:4]}; // [RQ7]
      alu_func        <= ir_src[15:12];                           // [RQ8]
      fmt_double      <= (ir_src[14:12] != 3'h0) && (ir_src[14:12] != 3'h7);
      fmt_single      <= (ir_src[14:11] == 4'h1);                 // [RQ8]
      fmt_branch      <= (ir_src[14:11] == 4'h0) && (ir_src[10:8] != 3'h0);
      src_is_pc       <= reg_is_pc(ir_src[8:6]);                  // [RQ8]
      dst_is_pc       <= reg_is_pc(ir_src[2:0]);                  // [RQ8]
      sys_bus_data_lo <= status_to_bus ? proc_status_word : 8'h00;  // [RQ13]
      reg_read_lo     <= status_to_read ? proc_status_word : 8'h00; // [RQ13]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // forced micro-address sequencing
  reg [3:0] pend_r;
  reg [1:0] state_r;
  reg [3:0] grant;
  reg [8:0] vec;
  wire [3:0] raise = {red_zone, bus_error, power_evt, init_evt};  // [RQ9]
  always @* begin
    grant = 4'h0;
    vec   = `VEC_INIT;
    if (pend_r[0]) begin
      grant = 4'h1;
      vec   = `VEC_INIT;                                          // [RQ18]
    end else if (pend_r[1]) begin
      grant = 4'h2;
      vec   = `VEC_POWER;
    end else if (pend_r[2]) begin
      grant = 4'h4;
      vec   = `VEC_BUS_ERR;
    end else if (pend_r[3]) begin
      grant = 4'h8;
      vec   = `VEC_OVERFLOW;
    end
  end
  wire [3:0] taken = (state_r == ST_IDLE) ? grant : 4'h0;
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pend_r               <= 4'h0;
      state_r              <= ST_IDLE;
      {forced_set, forced_clr} <= 18'h00000;
      {forced_micro_address, uword_load} <= 2'h0;
    end else if (clk_en) begin
      pend_r <= (pend_r & ~taken) | raise;                        // [RQ9]
      case (state_r)
        ST_IDLE: begin
          uword_load <= 1'b0;
          if (grant != 4'h0) begin
            forced_set           <= vec;                          // [RQ10]
            forced_clr           <= ~vec;                         // [RQ10]
            forced_micro_address <= 1'b1;
            state_r              <= ST_FORCE;
          end
        end
        ST_FORCE: begin
          {forced_set, forced_clr} <= 18'h00000;
          forced_micro_address <= 1'b0;
          uword_load           <= 1'b1;                           // [RQ11]
          state_r              <= ST_LOAD;
        end
        ST_LOAD: begin
          uword_load <= 1'b0;
          state_r    <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  reg              aw_got_r;
  reg              w_got_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg [31:0]       w_data_r;
  reg [3:0]        w_strb_r;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & is_off(aw_addr_r, `OFF_CTRL);
  wire wr_en   = wr_go & is_off(aw_addr_r, `OFF_IRQ_ENABLE);
  wire wr_clr  = wr_go & is_off(aw_addr_r, `OFF_IRQ_CLEAR) & w_strb_r[0];
  wire wr_ok   = is_off(aw_addr_r, `OFF_CTRL) | is_off(aw_addr_r, `OFF_IRQ_ENABLE) |
                 is_off(aw_addr_r, `OFF_IRQ_CLEAR);
  wire [4:0] clr_bits = wr_clr ? w_data_r[4:0] : 5'h00;
  wire [4:0] evt_bits = {ovf_zone, init_evt, power_evt, red_zone, bus_error};
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      {aw_got_r, w_got_r} <= 2'h0;
      aw_addr_r       <= {ADDR_W{1'b0}};
      w_data_r        <= 32'h00000000;
      w_strb_r        <= 4'h0;
      {s_axi_awready, s_axi_wready} <= 2'h3;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= `RESP_OKAY;
      stack_limit_reg <= `RST_STACK_LIMIT;
      irq_enable_r    <= `RST_IRQ_ENABLE;
      irq_status_r    <= 5'h00;
      irq             <= 1'b0;
    end else if (clk_en) begin
      if (aw_fire) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        {aw_got_r, w_got_r} <= 2'h0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        {s_axi_awready, s_axi_wready} <= 2'h3;
      end
      if (wr_ctrl & w_strb_r[0])
        stack_limit_reg <= w_data_r[7:0];
      if (wr_en & w_strb_r[0])
        irq_enable_r <= w_data_r[4:0];
      // a new event wins over a clear in the same cycle
      irq_status_r <= (irq_status_r & ~clr_bits) | evt_bits;
      irq          <= |(irq_status_r & irq_enable_r);
    end
  end
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (is_off(s_axi_araddr, `OFF_CTRL))
      rd_word = {24'h000000, stack_limit_reg};
    else if (is_off(s_axi_araddr, `OFF_IRQ_STATUS))
      rd_word = {27'h0000000, irq_status_r};
    else if (is_off(s_axi_araddr, `OFF_IRQ_ENABLE))
      rd_word = {27'h0000000, irq_enable_r};
    else if (is_off(s_axi_araddr, `OFF_STATE))
      rd_word = {instr_reg, proc_status_word, 6'h00, state_r};    // [RQ14]
    else if (is_off(s_axi_araddr, `OFF_POINTER))
      rd_word = {7'h00, past_micro_pointer, 12'h000, pend_r};
  end
  wire rd_ok = is_off(s_axi_araddr, `OFF_CTRL) | is_off(s_axi_araddr, `OFF_IRQ_STATUS) |
               is_off(s_axi_araddr, `OFF_IRQ_ENABLE) | is_off(s_axi_araddr, `OFF_STATE) |
               is_off(s_axi_araddr, `OFF_POINTER);
  always @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // pds_core
`default_nettype wire

// ===== verification/pds_core_props.sv
// checker for pds_core: decode, pointer and forcing relations
// assumes clk_en held high by the sequencer model
`timescale 1ns/1ps
`default_nettype none
`include "pds_consts.vh"
module pds_core_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [15:0] internal_data_mux,
  input wire logic [15:0] temp_data_reg,
  input wire logic [17:0] bus_addr,
  input wire logic        stack_ref,
  input wire logic [8:0]  micro_pointer,
  input wire logic        ir_load,
  input wire logic        status_to_bus,
  input wire logic        sys_init,
  input wire logic [15:0] data_display,
  input wire logic        sel_status,
  input wire logic        overflow_stop,
  input wire logic        overflow_flag,
  input wire logic        zero_data,
  input wire logic [8:0]  buffered_micro_pointer,
  input wire logic [8:0]  expansion_micro_pointer,
  input wire logic [8:0]  past_micro_pointer,
  input wire logic [15:0] instr_reg,
  input wire logic [8:0]  forced_set,
  input wire logic [8:0]  forced_clr,
  input wire logic        forced_micro_address,
  input wire logic        uword_load,
  input wire logic [7:0]  proc_status_word,
  input wire logic [7:0]  sys_bus_data_lo
);
  logic [1:0] up_r;
  logic       live;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  assign live = (up_r == 2'h3);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_display_inverted:
    assert property (live |-> data_display == ~$past(internal_data_mux))
    else $error("display not inverted mux");
  a_select_status:
    assert property (live |-> sel_status == ($past(bus_addr) == `ADDR_STATUS))
    else $error("status select wrong");
  a_overflow_pair:
    assert property (live |-> overflow_stop == overflow_flag && (!overflow_flag || $past(stack_ref)))
    else $error("overflow signals disagree");
  a_zero_data:
    assert property (live |-> zero_data == ($past(temp_data_reg) == 16'h0000))
    else $error("zero data wrong");
  a_pointer_copies:
    assert property (live |-> buffered_micro_pointer == $past(micro_pointer)
                     && expansion_micro_pointer == $past(micro_pointer))
    else $error("pointer copies wrong");
  a_past_pointer:
    assert property (live |-> past_micro_pointer == $past(micro_pointer))
    else $error("past pointer wrong");
  a_instr_load:
    assert property (live && $past(ir_load) && !$past(sys_init) |-> instr_reg == $past(internal_data_mux))
    else $error("instruction not loaded");
  a_init_clears:
    assert property (live && $past(sys_init) |-> instr_reg == 16'h0000 && proc_status_word == 8'h00)
    else $error("init did not clear");
  a_status_gate:
    assert property (live |-> sys_bus_data_lo == ($past(status_to_bus) ? $past(proc_status_word) : 8'h00))
    else $error("status bus gate wrong");
  a_forced_vector:
    assert property (forced_micro_address |-> forced_clr == ~forced_set && forced_set inside
                     {`VEC_INIT, `VEC_POWER, `VEC_BUS_ERR, `VEC_OVERFLOW})
    else $error("forced vector wrong");
  a_load_follows:
    assert property (forced_micro_address |=> uword_load)
    else $error("no microword load after force");
  a_one_service:
    assert property (forced_micro_address |=> (!forced_micro_address) [*2])
    else $error("forcing too close");
endmodule // pds_core_props
bind pds_core pds_core_props u_props (.*);
`default_nettype wire

// ===== verification/processor_decode_and_status_bench.sv
// bench for pds_core: random datapath traffic, registers, forcing
// assumes pds_core with ADDR_W 8 and the sequencer model beside it
`timescale 1ns/1ps
`default_nettype none
`include "pds_consts.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module processor_decode_and_status_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, stack_ref = 1'b0, ir_load = 1'b0;
  logic [15:0] internal_data_mux = 16'h0000, temp_data_reg = 16'h0000;
  logic [17:0] bus_addr = 18'h00000, prev_addr = 18'h00000;
  logic status_load_mux = 1'b0, status_load_cc = 1'b0, status_to_bus = 1'b0;
  logic status_to_read = 1'b0, sys_init = 1'b0, bus_error = 1'b0;
  logic power_restart = 1'b0, console_init = 1'b0, prev_rdg = 1'b0;
  logic [7:0] cond_code_in = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, prev_ps;
  logic [31:0] s_axi_wdata = 32'h0, seed = 32'hcf5c, rd;
  logic [3:0] s_axi_wstrb = 4'hF, up = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] rsp;
  logic [15:0] prev_temp = 16'h0000;
  logic [17:0] hot [4] = '{`ADDR_STATUS, `ADDR_STACK_LIM, 18'h3FFC5, `ADDR_SWITCH};
  int num_errors = 0;
  int cmp_count = 0;
  wire clk_en, sel_status, sel_stack_limit, sel_scratch, sel_switch, overflow_stop;
  wire overflow_flag, zero_data, fmt_double, fmt_single, fmt_branch, src_is_pc, dst_is_pc;
  wire forced_micro_address, uword_load, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [8:0] micro_pointer, loaded_addr, buffered_micro_pointer, expansion_micro_pointer;
  wire [8:0] past_micro_pointer, forced_set, forced_clr;
  wire [15:0] data_display, instr_reg;
  wire [2:0] src_reg_num, dst_reg_num;
  wire [5:0] ir_branch_bits;
  wire [3:0] alu_func;
  wire [7:0] proc_status_word, sys_bus_data_lo, reg_read_lo;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  always #20 clk_sys = ~clk_sys;
  pds_core #(.ADDR_W(8)) u_dut (.*);
  useq_model u_seq (.clk_sys(clk_sys), .rst_n(rst_n), .forced_set(forced_set),
    .forced_clr(forced_clr), .forced_micro_address(forced_micro_address),
    .uword_load(uword_load), .clk_en(clk_en), .micro_pointer(micro_pointer),
    .loaded_addr(loaded_addr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] sel_exp(input logic [17:0] a);
    return {a == `ADDR_STATUS, a == `ADDR_STACK_LIM, a >= 18'h3FFC0 && a <= 18'h3FFCF,
            a == `ADDR_SWITCH};
  endfunction
  always @(posedge clk_sys) begin
    if (up >= 4'h3) begin
      `CHK({sel_status, sel_stack_limit, sel_scratch, sel_switch}, sel_exp(prev_addr))
      `CHK(zero_data, prev_temp == 16'h0000)
      `CHK(reg_read_lo, prev_rdg ? prev_ps : 8'h00)
    end
    prev_addr = bus_addr;
    prev_temp = temp_data_reg;
    prev_rdg = status_to_read;
    prev_ps = proc_status_word;
    up = !rst_n ? 4'h0 : (up == 4'hF ? up : up + 4'h1);
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic see_force(input logic [8:0] v);
    do @(posedge clk_sys); while (forced_micro_address !== 1'b1);
    `CHK(forced_set, v)
    `CHK(forced_clr, ~v)
    @(posedge clk_sys);
    `CHK(uword_load, 1'b1)
    @(posedge clk_sys);
    `CHK(loaded_addr, v)
  endtask
  task final_report;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #800000;
    num_errors++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    axi_wr(`OFF_CTRL, 32'h40);
    `CHK(rsp, `RESP_OKAY)
    axi_wr(`OFF_IRQ_ENABLE, 32'h1F);
    axi_rd(`OFF_CTRL);
    `CHK(rd, 32'h40)
    axi_rd(8'h1C);
    `CHK(rsp, `RESP_SLVERR)
    axi_rd(`OFF_IRQ_CLEAR);
    `CHK(rsp, `RESP_SLVERR)
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      repeat (7) seed = lfsr(seed);
      internal_data_mux <= seed[31:16];
      temp_data_reg <= seed[3:0] == 4'h0 ? 16'h0000 : seed[15:0];
      bus_addr <= seed[4] ? hot[seed[6:5]] : seed[17:0];
      {ir_load, status_load_mux, status_load_cc, status_to_bus, status_to_read} <= seed[11:7];
      cond_code_in <= seed[27:20];
      sys_init <= seed[15:12] == 4'h0;
    end
    @(posedge clk_sys);
    {ir_load, status_load_mux, status_load_cc, sys_init} <= 4'h8;
    internal_data_mux <= 16'hA5C3;
    @(posedge clk_sys);
    ir_load <= 1'b0;
    internal_data_mux <= 16'h0F0F;
    repeat (2) @(posedge clk_sys);
    `CHK(instr_reg, 16'hA5C3)
    `CHK({src_reg_num, dst_reg_num}, 6'h3B)
    `CHK(ir_branch_bits, 6'h28)
    `CHK({alu_func, fmt_double, fmt_single, fmt_branch, src_is_pc, dst_is_pc}, 9'h152)
    power_restart <= 1'b1;
    console_init <= 1'b1;
    see_force(`VEC_INIT);
    see_force(`VEC_POWER);
    `CHK(instr_reg, 16'h0000)
    {power_restart, console_init} <= 2'h0;
    status_load_cc <= 1'b1;
    cond_code_in <= 8'h96;
    @(posedge clk_sys);
    status_load_cc <= 1'b0;
    @(posedge clk_sys);
    `CHK(proc_status_word, 8'h96)
    {status_load_mux, status_load_cc, sys_init} <= 3'h7;
    @(posedge clk_sys);
    sys_init <= 1'b0;
    @(posedge clk_sys);
    `CHK(proc_status_word, 8'h00)
    {status_load_mux, status_load_cc} <= 2'h0;
    @(posedge clk_sys);
    `CHK(proc_status_word, 8'h0F)
    axi_wr(`OFF_IRQ_CLEAR, 32'h1F);
    for (int m = 0; m < 2; m++) begin
      bus_error <= 1'b1;
      @(posedge clk_sys);
      bus_error <= 1'b0;
      see_force(`VEC_BUS_ERR);
      axi_rd(`OFF_IRQ_STATUS);
      `CHK(rd, 32'h1)
      `CHK(irq, m == 0)
      axi_wr(`OFF_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 1'b0)
      axi_wr(`OFF_IRQ_ENABLE, 32'h0);
    end
    axi_wr(`OFF_IRQ_ENABLE, 32'h1F);
    {bus_error, stack_ref} <= 2'h3;
    bus_addr <= 18'h01000;
    @(posedge clk_sys);
    {bus_error, stack_ref} <= 2'h0;
    see_force(`VEC_BUS_ERR);
    see_force(`VEC_OVERFLOW);
    stack_ref <= 1'b1;
    bus_addr <= 18'h04000;
    @(posedge clk_sys);
    stack_ref <= 1'b0;
    @(posedge clk_sys);
    `CHK({overflow_stop, overflow_flag}, 2'h3)
    axi_rd(`OFF_IRQ_STATUS);
    `CHK(rd, 32'h13)
    final_report;
  end
endmodule // processor_decode_and_status_bench
`default_nettype wire

// ===== verification/useq_model.sv
// sequencer model: steps the micro pointer and obeys forcing
// assumes pds_core on the same clk_sys, clock enable held high
`timescale 1ns/1ps
`default_nettype none
module useq_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [8:0] forced_set,
  input  wire logic [8:0] forced_clr,
  input  wire logic       forced_micro_address,
  input  wire logic       uword_load,
  output wire logic       clk_en,
  output var  logic [8:0] micro_pointer,
  output var  logic [8:0] loaded_addr
);
  assign clk_en = 1'b1;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      micro_pointer <= 9'h000;
      loaded_addr   <= 9'h000;
    end else if (forced_micro_address) begin
      micro_pointer <= (micro_pointer | forced_set) & ~forced_clr;
    end else if (uword_load) begin
      loaded_addr   <= micro_pointer;
      micro_pointer <= micro_pointer + 9'h001;
    end else begin
      micro_pointer <= micro_pointer + 9'h005;
    end
  end
endmodule // useq_model
`default_nettype wire
